// *** hw/sac_top.sv ***
// Overview of operation
// - twelve-bit successive-approximation search, two arrays
// - one sample per microsecond at core clock
// - differential, single-ended or pseudo differential inputs
// - software single or continuous conversions
// - pin, logic array or timer overflow triggers
// - extra channel selects the temperature sensor
// - single-ended results in straight binary
// - differential results in two's complement
// - signed result shifted right by one
// - coefficients reset to factory values, writable
// - digital offset correction, quarter-lsb step
// - gain correction, quarter-lsb step
// - pollable done flag once result is ready
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module sac_top
  import sac_pkg::*;
#(
  parameter logic [SAC_COEF_BITS-1:0] OFFSET_FACTORY = SAC_OFFSET_RST,  // trimmed offset
  parameter logic [SAC_COEF_BITS-1:0] GAIN_FACTORY   = SAC_GAIN_RST     // trimmed gain
) (
  input  wire logic                      clk_sys,                      // core clock, 40 MHz
  input  wire logic                      reset,                        // async, active high
  input  wire logic                      clk_en,                       // freezes all state
  input  wire logic [7:0]                reg_addr,                     // byte address
  input  wire logic [31:0]               reg_wdata,                    // write data
  input  wire logic                      reg_wr,                       // write strobe
  input  wire logic                      reg_rd,                       // read strobe
  output logic [31:0]                    reg_rdata,                    // data after a read
  input  wire logic                      external_conversion_trigger,  // start pin
  input  wire logic                      programmable_logic_array,     // logic array output
  input  wire logic                      first_timer_overflow,         // timer pulse
  input  wire logic                      second_timer_overflow,        // timer pulse
  input  wire logic                      cmp_in,                       // comparator decision
  output logic                           sample_hold,                  // track phase
  output logic [SAC_RES_BITS-1:0]        trial_p,                      // positive array code
  output logic [SAC_RES_BITS-1:0]        trial_n,                      // negative array code
  output logic [SAC_CHAN_BITS-1:0]       chan_sel,                     // mux channel
  output logic                           temp_sensor_sel,              // temperature source
  output logic [1:0]                     input_mode,                   // input configuration
  output logic                           busy,                         // conversion running
  output logic                           irq                           // level interrupt
);
  import sac_pkg::*;

  // all control state of the block except the busy_reg shadow flop
  typedef struct packed {
    logic [1:0]               mode;       // input configuration
    logic [2:0]               ctype;      // conversion start source
    logic [SAC_CHAN_BITS-1:0] chan;       // selected channel
    logic [SAC_COEF_BITS-1:0] offset;     // offset_coefficient
    logic [SAC_COEF_BITS-1:0] gain;       // gain_coefficient
    logic [15:0]              result;     // conversion_result_register
    logic                     done_flag;  // conversion_done_flag
    logic [1:0]               irq_stat;   // sticky events
    logic [1:0]               irq_mask;   // event enables
    logic [31:0]              rdata;      // read answer
    logic                     single;     // one software start pending
    logic                     trig_prev;  // last level of the trigger source
    logic [7:0]               period;     // cycles until the next sample slot
    logic                     start;      // start pulse to the search engine
    logic                     irq;        // registered interrupt
    logic                     temp_sel;   // registered temperature select
  } sac_top_s;

  sac_top_s s_reg;
  sac_top_s s_next;

  // search engine and correction outputs
  logic                    sar_busy;    // engine not idle
  logic                    sar_done;    // raw code finished
  logic [SAC_RES_BITS-1:0] sar_raw;     // raw code
  logic [15:0]             corr_word;   // coded, corrected word
  logic                    corr_valid;  // word ready

  // helper terms
  logic       trig_level;   // level of the chosen hardware source
  logic       trig_edge;    // rising edge of it
  logic       can_start;    // engine idle, no start in flight and no result pending
  logic [1:0] ev_set;       // events this cycle
  logic [1:0] ev_clr;       // clear from an interrupt status read
  logic       cp_done;      // done flag set this cycle

  // the conversion engine itself
  sac_sar u_sar (
    .clk_sys     (clk_sys),
    .reset       (reset),
    .clk_en      (clk_en),
    .start       (s_reg.start),
    .cmp_in      (cmp_in),
    .sample_hold (sample_hold),
    .trial_p     (trial_p),
    .trial_n     (trial_n),
    .raw         (sar_raw),
    .done        (sar_done),
    .busy        (sar_busy)
  );

  // correction and coding after the search
  sac_corr u_corr (
    .clk_sys   (clk_sys),
    .reset     (reset),
    .clk_en    (clk_en),
    .in_valid  (sar_done),
    .raw       (sar_raw),
    .diff      (s_reg.mode == SAC_MODE_DIFF),
    .offset    (s_reg.offset),
    .gain      (s_reg.gain),
    .result    (corr_word),
    .out_valid (corr_valid)
  );

  // choose the hardware trigger source
  always_comb begin
    case (s_reg.ctype)
      SAC_TYPE_EXT:  trig_level = external_conversion_trigger;
      SAC_TYPE_PLA:  trig_level = programmable_logic_array;
      SAC_TYPE_TMR0: trig_level = first_timer_overflow;
      SAC_TYPE_TMR1: trig_level = second_timer_overflow;
      default:       trig_level = 1'b0;
    endcase
  end

  assign trig_edge = trig_level & ~s_reg.trig_prev;
  // a start in flight counts as busy, so no double start is issued
  assign can_start = ~sar_busy & ~s_reg.start & ~corr_valid & ~sar_done;

  // control, register access and start scheduling
  always_comb begin
    s_next           = s_reg;
    s_next.start     = 1'b0;
    s_next.trig_prev = trig_level;
    ev_set           = 2'b00;
    ev_clr           = 2'b00;
    cp_done          = 1'b0;

    // sample slot counter paces continuous mode to one per microsecond
    if (s_reg.period != 8'h00) begin
      s_next.period = s_reg.period - 8'h01;
    end

    // start requests
    case (s_reg.ctype)
      SAC_TYPE_SINGLE: begin
        if (s_reg.single && can_start) begin
          s_next.start  = 1'b1;
          s_next.single = 1'b0;
        end
      end
      SAC_TYPE_CONT: begin
        if (can_start && s_reg.period == 8'h00) begin
          s_next.start  = 1'b1;
          s_next.period = 8'(SAC_SAMPLE_CYCLES - 1);
        end
      end
      SAC_TYPE_EXT, SAC_TYPE_PLA, SAC_TYPE_TMR0, SAC_TYPE_TMR1: begin
        // a trigger during a conversion is dropped and reported
        if (trig_edge) begin
          if (can_start) begin
            s_next.start = 1'b1;
          end else begin
            ev_set[SAC_EV_OVERRUN] = 1'b1;
          end
        end
      end
      default: begin
        s_next.single = 1'b0;
      end
    endcase

    // finished word lands whole in the result register
    if (corr_valid) begin
      s_next.result        = corr_word;
      cp_done              = 1'b1;
      ev_set[SAC_EV_DONE]  = 1'b1;
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        SAC_CTRL_OFS: begin
          s_next.mode   = reg_wdata[SAC_CTRL_MODE_LSB +: 2];
          s_next.ctype  = reg_wdata[SAC_CTRL_TYPE_LSB +: 3];
          s_next.single = (reg_wdata[SAC_CTRL_TYPE_LSB +: 3] == SAC_TYPE_SINGLE);
        end
        SAC_CHAN_OFS:     s_next.chan     = reg_wdata[SAC_CHAN_BITS-1:0];
        SAC_OFFSET_OFS:   s_next.offset   = reg_wdata[SAC_COEF_BITS-1:0];
        SAC_GAIN_OFS:     s_next.gain     = reg_wdata[SAC_COEF_BITS-1:0];
        SAC_IRQ_MASK_OFS: s_next.irq_mask = reg_wdata[1:0];
        default: begin
          s_next.irq_mask = s_reg.irq_mask;
        end
      endcase
    end

    // register reads, answered one cycle later
    if (reg_rd) begin
      case (reg_addr)
        SAC_CTRL_OFS:     s_next.rdata = {27'h0, s_reg.ctype, s_reg.mode};
        SAC_CHAN_OFS:     s_next.rdata = {27'h0, s_reg.chan};
        SAC_STATUS_OFS:   s_next.rdata = {30'h0, sar_busy, s_reg.done_flag};
        SAC_RESULT_OFS:   s_next.rdata = {{16{s_reg.result[15]}}, s_reg.result};
        SAC_OFFSET_OFS:   s_next.rdata = 32'(signed'(s_reg.offset));
        SAC_GAIN_OFS:     s_next.rdata = 32'(signed'(s_reg.gain));
        SAC_IRQ_STAT_OFS: s_next.rdata = {30'h0, s_reg.irq_stat};
        SAC_IRQ_MASK_OFS: s_next.rdata = {30'h0, s_reg.irq_mask};
        default:          s_next.rdata = 32'h0000_0000;  // unmapped reads zero
      endcase
      if (reg_addr == SAC_IRQ_STAT_OFS) begin
        ev_clr = 2'b11;
      end
    end

    // a result read clears the done flag, but a new result wins
    if (reg_rd && reg_addr == SAC_RESULT_OFS) begin
      s_next.done_flag = 1'b0;
    end
    if (cp_done) begin
      s_next.done_flag = 1'b1;
    end

    // sticky events: set beats the read clear
    s_next.irq_stat = (s_reg.irq_stat & ~ev_clr) | ev_set;
    s_next.irq      = |(s_next.irq_stat & s_next.irq_mask);
    // the temperature channel steers the mux to the sensor
    s_next.temp_sel = (s_next.chan == SAC_TEMP_CHAN);
  end

  // state register; coefficients come back to the trimmed values on reset
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_reg           <= '0;
      s_reg.offset    <= OFFSET_FACTORY;
      s_reg.gain      <= GAIN_FACTORY;
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  // busy is registered here so all outputs but sample_hold and trial_n come from flops
  logic busy_reg;

  // shadow of engine activity for the busy pin
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      busy_reg <= 1'b0;
    end else if (clk_en) begin
      busy_reg <= sar_busy | s_reg.start;
    end
  end

  assign reg_rdata       = s_reg.rdata;
  assign chan_sel        = s_reg.chan;
  assign temp_sensor_sel = s_reg.temp_sel;
  assign input_mode      = s_reg.mode;
  assign busy            = busy_reg;
  assign irq             = s_reg.irq;

endmodule
`default_nettype wire

// *** hw/sac_pkg.sv ***
// shared constants for the successive-approximation converter control block
package sac_pkg;

  // register byte offsets on the plain register port
  localparam logic [7:0] SAC_CTRL_OFS     = 8'h00;  // mode, conversion type
  localparam logic [7:0] SAC_CHAN_OFS     = 8'h04;  // input channel select
  localparam logic [7:0] SAC_STATUS_OFS   = 8'h08;  // conversion_done_flag, busy
  localparam logic [7:0] SAC_RESULT_OFS   = 8'h0c;  // conversion_result_register
  localparam logic [7:0] SAC_OFFSET_OFS   = 8'h10;  // offset_coefficient
  localparam logic [7:0] SAC_GAIN_OFS     = 8'h14;  // gain_coefficient
  localparam logic [7:0] SAC_IRQ_STAT_OFS = 8'h18;  // sticky events, read clears
  localparam logic [7:0] SAC_IRQ_MASK_OFS = 8'h1c;  // event enables

  // field layout of the control register
  localparam int SAC_CTRL_MODE_LSB = 0;   // two bits of input configuration
  localparam int SAC_CTRL_TYPE_LSB = 2;   // three bits of conversion type

  // field layout of status and interrupt registers
  localparam int SAC_EV_DONE    = 0;  // a result was stored
  localparam int SAC_EV_OVERRUN = 1;  // a trigger came while converting
  localparam int SAC_STAT_BUSY  = 1;  // status bit 1 shows the engine busy

  // input configurations
  typedef enum logic [1:0] {
    SAC_MODE_SINGLE = 2'h0,  // single-ended, straight binary
    SAC_MODE_DIFF   = 2'h1,  // fully differential, two's complement
    SAC_MODE_PSEUDO = 2'h2   // pseudo differential, straight binary
  } sac_mode_e;

  // conversion start sources
  typedef enum logic [2:0] {
    SAC_TYPE_OFF    = 3'h0,  // no conversions
    SAC_TYPE_SINGLE = 3'h1,  // one conversion per write
    SAC_TYPE_CONT   = 3'h2,  // software conversions, one per sample slot
    SAC_TYPE_EXT    = 3'h3,  // external_conversion_trigger rising edge
    SAC_TYPE_PLA    = 3'h4,  // programmable_logic_array output rising edge
    SAC_TYPE_TMR0   = 3'h5,  // first_timer_overflow pulse
    SAC_TYPE_TMR1   = 3'h6   // second_timer_overflow pulse
  } sac_type_e;

  // widths and codes
  localparam int          SAC_RES_BITS  = 12;      // converter resolution
  localparam int          SAC_COEF_BITS = 10;      // signed quarter-lsb coefficients
  localparam int          SAC_CHAN_BITS = 5;       // channel select width
  localparam logic [4:0]  SAC_TEMP_CHAN = 5'h10;   // temperature sensor channel

  // factory coefficient defaults; real parts load trimmed values here
  localparam logic [9:0]  SAC_OFFSET_RST = 10'h000;
  localparam logic [9:0]  SAC_GAIN_RST   = 10'h000;

  // timing: sample period at full throughput, derived at the 40 MHz core clock
  localparam int SAC_CLK_HZ        = 40000000;
  localparam int SAC_SAMPLE_NS     = 1000;   // one million samples per second
  localparam int SAC_SAMPLE_CYCLES = (SAC_SAMPLE_NS * (SAC_CLK_HZ / 1000000)) / 1000;
  localparam int SAC_TRACK_CYCLES  = 6;      // acquisition before the bit search

endpackage

// *** hw/sac_sar.sv ***
`timescale 1ns/1ps
`default_nettype none
// bit search over two complementary capacitor arrays
module sac_sar
  import sac_pkg::*;
(
  input  wire logic                    clk_sys,     // core clock
  input  wire logic                    reset,       // async, active high
  input  wire logic                    clk_en,      // freezes all state when low
  input  wire logic                    start,       // begin one conversion
  input  wire logic                    cmp_in,      // high: input above trial level
  output logic                         sample_hold, // high while tracking
  output logic [SAC_RES_BITS-1:0]      trial_p,     // positive array code
  output logic [SAC_RES_BITS-1:0]      trial_n,     // negative array code
  output logic [SAC_RES_BITS-1:0]      raw,         // finished code
  output logic                         done,        // one-cycle pulse at end
  output logic                         busy         // engine not idle
);
  import sac_pkg::*;

  typedef enum logic [3:0] {
    SAR_IDLE  = 4'h1,
    SAR_TRACK = 4'h2,
    SAR_BITS  = 4'h4,
    SAR_DONE  = 4'h8
  } sac_sar_state_e;

  typedef struct packed {
    sac_sar_state_e          st;     // search phase
    logic [3:0]              cnt;    // track cycles or bit index
    logic [SAC_RES_BITS-1:0] code;   // code under test
    logic [SAC_RES_BITS-1:0] raw;    // last finished code
    logic                    done;   // end pulse
  } sac_sar_s;

  sac_sar_s s_reg;
  sac_sar_s s_next;

  // one step of the binary search per clock
  always_comb begin
    s_next      = s_reg;
    s_next.done = 1'b0;
    case (s_reg.st)
      SAR_IDLE: begin
        if (start) begin
          s_next.st  = SAR_TRACK;
          s_next.cnt = 4'(SAC_TRACK_CYCLES - 1);
        end
      end
      SAR_TRACK: begin
        // start at mid-scale, msb trial first
        if (s_reg.cnt == 4'h0) begin
          s_next.st   = SAR_BITS;
          s_next.cnt  = 4'(SAC_RES_BITS - 1);
          s_next.code = {1'b1, {(SAC_RES_BITS-1){1'b0}}};
        end else begin
          s_next.cnt = s_reg.cnt - 4'h1;
        end
      end
      SAR_BITS: begin
        // keep or drop the bit under test, then try the next lower one
        if (!cmp_in) begin
          s_next.code[s_reg.cnt] = 1'b0;
        end
        if (s_reg.cnt == 4'h0) begin
          s_next.st = SAR_DONE;
        end else begin
          s_next.cnt                    = s_reg.cnt - 4'h1;
          s_next.code[s_reg.cnt - 4'h1] = 1'b1;
        end
      end
      SAR_DONE: begin
        s_next.raw  = s_reg.code;
        s_next.done = 1'b1;
        s_next.st   = SAR_IDLE;
      end
      default: begin
        s_next.st = SAR_IDLE;
      end
    endcase
  end

  // state register, held while the clock enable is low
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_reg <= '{st: SAR_IDLE, cnt: 4'h0, code: '0, raw: '0, done: 1'b0};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign sample_hold = (s_reg.st == SAR_TRACK);
  assign trial_p     = s_reg.code;
  assign trial_n     = ~s_reg.code;  // second array steps the other way
  assign raw         = s_reg.raw;
  assign done        = s_reg.done;
  assign busy        = (s_reg.st != SAR_IDLE);

endmodule
`default_nettype wire

// *** hw/sac_corr.sv ***
`timescale 1ns/1ps
`default_nettype none
// digital offset and gain correction plus output coding
module sac_corr
  import sac_pkg::*;
(
  input  wire logic                      clk_sys,  // core clock
  input  wire logic                      reset,    // async, active high
  input  wire logic                      clk_en,   // freezes all state when low
  input  wire logic                      in_valid, // raw code ready
  input  wire logic [SAC_RES_BITS-1:0]   raw,      // offset-binary code
  input  wire logic                      diff,     // fully differential coding
  input  wire logic [SAC_COEF_BITS-1:0]  offset,   // signed, quarter lsb
  input  wire logic [SAC_COEF_BITS-1:0]  gain,     // signed, quarter lsb at full scale
  output logic [15:0]                    result,   // coded word
  output logic                           out_valid // one-cycle pulse
);
  import sac_pkg::*;

  typedef struct packed {
    logic [15:0] result;  // coded word
    logic        valid;   // pulse with the word
  } sac_corr_s;

  sac_corr_s s_reg;
  sac_corr_s s_next;

  logic signed [13:0] x;      // sample as signed lsb count
  logic signed [23:0] prod;   // gain term before scaling
  logic signed [17:0] q;      // corrected value in quarter lsb
  logic signed [17:0] r;      // rounded to whole lsb
  logic signed [11:0] code;   // clamped code

  // correct in quarter steps, round once, clamp to the code range
  always_comb begin
    s_next       = s_reg;
    s_next.valid = in_valid;
    // differential codes are centred on zero, single-ended on ground
    if (diff) begin
      x = 14'(signed'({2'b00, raw}) - 14'sd2048);
    end else begin
      x = signed'({2'b00, raw});
    end
    prod = 24'(x * signed'(gain));
    q    = 18'(x) * 18'sd4 + 18'(signed'(offset)) + 18'(prod >>> 12);
    r    = (q + 18'sd2) >>> 2;
    code = 12'(r);
    if (diff) begin
      // two's complement, sat to the signed span
      if (r > 18'sd2047) begin
        code = 12'sd2047;
      end else if (r < -18'sd2048) begin
        code = -12'sd2048;
      end
      // halved so the word reads as a signed integer
      if (in_valid) begin
        s_next.result = 16'(signed'(code) >>> 1);
      end
    end else begin
      // straight binary, one step per fs/4096
      if (r > 18'sd4095) begin
        code = 12'hfff;
      end else if (r < 18'sd0) begin
        code = 12'h000;
      end
      if (in_valid) begin
        s_next.result = {4'h0, code};
      end
    end
  end

  // whole word changes in one edge only
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      s_reg <= '{result: 16'h0000, valid: 1'b0};
    end else if (clk_en) begin
      s_reg <= s_next;
    end
  end

  assign result    = s_reg.result;
  assign out_valid = s_reg.valid;

endmodule
`default_nettype wire

// *** tb/sac_top_props.sv ***
`timescale 1ns/1ps
`default_nettype none
// port-level checks of the converter control block
module sac_top_props
  import sac_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        reset,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [31:0] reg_wdata,
  input wire logic [31:0] reg_rdata,
  input wire logic        sample_hold,
  input wire logic [11:0] trial_p,
  input wire logic [11:0] trial_n,
  input wire logic [4:0]  chan_sel,
  input wire logic        temp_sensor_sel,
  input wire logic [1:0]  input_mode,
  input wire logic        busy,
  input wire logic        irq
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // both arrays always carry opposite codes
  trial_pair_a: assert property (trial_n == ~trial_p) else $error("trial codes differ");
  // the search starts at mid scale right after tracking
  first_trial_a: assert property ($fell(sample_hold) |-> ##[0:1] trial_p == 12'h800)
    else $error("first trial not mid scale");
  // track phase is exactly six cycles
  track_len_a: assert property ($rose(sample_hold) |-> sample_hold[*6] ##1 !sample_hold)
    else $error("track length wrong");
  temp_route_a: assert property (chan_sel == SAC_TEMP_CHAN |-> ##[0:1] temp_sensor_sel)
    else $error("temperature source not routed");
  mode_back_a: assert property (reg_rd && reg_addr == SAC_CTRL_OFS |=>
    reg_rdata[1:0] == $past(input_mode)) else $error("mode readback wrong");
  chan_back_a: assert property (reg_rd && reg_addr == SAC_CHAN_OFS |=>
    reg_rdata[4:0] == $past(chan_sel)) else $error("channel readback wrong");
  single_go_a: assert property (reg_wr && reg_addr == SAC_CTRL_OFS && reg_wdata[4:2] == 3'h1
    && !busy && !sample_hold |-> ##[1:3] sample_hold) else $error("single start lost");
  // irq only drops after software touched the registers
  irq_drop_a: assert property ($fell(irq) |-> $past(reg_rd || reg_wr)
    || $past(reg_rd || reg_wr, 2)) else $error("irq dropped by itself");
  cover property ($rose(irq));
  cover property ($rose(temp_sensor_sel));
  cover property ($rose(sample_hold) && input_mode == 2'h1);
endmodule
`default_nettype wire

// *** tb/sac_afe.sv ***
`timescale 1ns/1ps
`default_nettype none
// analog front end: tracks the level, then compares against trial codes
module sac_afe (
  input  wire logic        clk_sys,
  input  wire logic        reset,
  input  wire logic        sample_hold,
  input  wire logic [11:0] trial_p,
  input  wire logic [11:0] vin,
  output logic             cmp_in
);
  logic [11:0] held;  // level frozen for the bit search
  // capture only while tracking, so later vin changes cannot leak in
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) held <= 12'h000;
    else if (sample_hold) held <= vin;
  end
  // high keeps the bit under test
  assign cmp_in = (held >= trial_p);
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import sac_pkg::*;
  logic        clk_sys, reset, reg_wr, reg_rd, cmp_in, busy, irq, sample_hold, temp_sensor_sel;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [11:0] trial_p, trial_n, vin;
  logic [4:0]  chan_sel;
  logic [1:0]  input_mode;
  logic [3:0]  trig;  // pin, logic array, first_timer_overflow, second_timer_overflow
  int          fail_count, tests_run;
  sac_top sac_top_inst (.clk_sys, .reset, .clk_en(1'b1), .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .external_conversion_trigger(trig[0]),
    .programmable_logic_array(trig[1]), .first_timer_overflow(trig[2]),
    .second_timer_overflow(trig[3]), .cmp_in, .sample_hold, .trial_p, .trial_n, .chan_sel,
    .temp_sensor_sel, .input_mode, .busy, .irq);
  sac_afe sac_afe_inst (.clk_sys, .reset, .sample_hold, .trial_p, .vin, .cmp_in);
  // 40 MHz core clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("mismatches %0d, checks %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_sys); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk_sys); reg_wr <= 1'b0;
  endtask
  // read data stand from the cycle after the strobe until the next read
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys); reg_rd <= 1'b0; #1 d = reg_rdata;
  endtask
  task automatic pulse(input int k);
    @(posedge clk_sys); trig[k] <= 1'b1;
    @(posedge clk_sys); trig[k] <= 1'b0;
  endtask
  // quarter-lsb correction, rounding, clamp and coding
  function automatic logic [31:0] expect_code(bit diff, int v, int off, int g);
    int x, c;
    x = diff ? v - 2048 : v;
    c = (4 * x + off + ((g * x) >>> 12) + 2) >>> 2;
    if (diff) return 32'((c < -2048 ? -2048 : (c > 2047 ? 2047 : c)) >>> 1);
    return 32'(c < 0 ? 0 : (c > 4095 ? 4095 : c));
  endfunction
  task automatic wait_done();
    int n;
    for (n = 0; n < 50; n++) begin
      rd(SAC_STATUS_OFS);
      if (d[SAC_EV_DONE] === 1'b1) break;
    end
    if (n == 50) begin
      fail_count++;
      end_of_test();
    end
  endtask
  // one full conversion with result, flag and interrupt checks
  task automatic conv(input logic [1:0] m, input logic [2:0] t, input int v, off, g);
    vin <= 12'(v);
    wr(SAC_OFFSET_OFS, 32'(off));
    wr(SAC_GAIN_OFS, 32'(g));
    wr(SAC_CTRL_OFS, {27'h0, t, m});
    if (t >= 3) pulse(t - 3);
    wait_done();
    chk(32'(irq), 32'h1);
    rd(SAC_RESULT_OFS);
    chk(d, expect_code(m == 2'h1, v, off, g));
    rd(SAC_IRQ_STAT_OFS);
    chk(d, 32'h1);
    @(posedge clk_sys); #1 chk(32'(irq), 32'h0);
    chk(32'(busy), 32'h0);
  endtask
  initial begin
    int v, off, g;
    reset = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 8'h00; reg_wdata = 32'h0;
    vin = 12'h000; trig = 4'h0; d = 32'h0; fail_count = 0; tests_run = 0;
    void'($urandom(32'hc21b));
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    rd(SAC_OFFSET_OFS);
    chk(d, {{22{SAC_OFFSET_RST[9]}}, SAC_OFFSET_RST});
    rd(SAC_GAIN_OFS);
    chk(d, {{22{SAC_GAIN_RST[9]}}, SAC_GAIN_RST});
    rd(8'h40);
    chk(d, 32'h0);
    wr(SAC_IRQ_MASK_OFS, 32'h1);
    // corner codes first, then random levels and coefficients in every mode
    for (int i = 0; i < 12; i++) begin
      v = i == 0 ? 0 : (i == 1 ? 4095 : (i == 2 ? 2048 : $urandom_range(4095)));
      off = i < 3 ? 0 : int'($urandom_range(200)) - 100;
      g = i < 3 ? 0 : int'($urandom_range(200)) - 100;
      conv(2'(i % 3), SAC_TYPE_SINGLE, v, off, g);
    end
    for (int t = 3; t <= 6; t++) conv(2'h0, 3'(t), $urandom_range(4095), 0, 0);
    // a second pin edge while converting is dropped and flagged
    vin <= 12'd777;
    wr(SAC_CTRL_OFS, {27'h0, SAC_TYPE_EXT, 2'h0});
    pulse(0);
    repeat (3) @(posedge clk_sys);
    pulse(0);
    wait_done();
    rd(SAC_RESULT_OFS);
    chk(d, 32'd777);
    rd(SAC_IRQ_STAT_OFS);
    chk(d, 32'h3);
    // software trims offset at ground, then gain at full scale
    off = 12; d = 32'hff;
    for (int k = 0; k < 8 && d > 1; k++) begin
      conv(2'h0, SAC_TYPE_SINGLE, 0, off, 0);
      rd(SAC_RESULT_OFS);
      off--;
    end
    chk(32'(d <= 1), 32'h1);
    g = -12; d = 32'h0;
    for (int k = 0; k < 8 && d < 4094; k++) begin
      conv(2'h0, SAC_TYPE_SINGLE, 4095, 0, g);
      rd(SAC_RESULT_OFS);
      g++;
    end
    chk(32'(d >= 4094), 32'h1);
    conv(2'h1, SAC_TYPE_CONT, 1000, 0, 0);
    wait_done();
    rd(SAC_RESULT_OFS);
    chk(d, expect_code(1'b1, 1000, 0, 0));
    rd(SAC_CTRL_OFS);
    chk(d, {27'h0, SAC_TYPE_CONT, 2'h1});
    wr(SAC_CTRL_OFS, 32'h0);
    wr(SAC_CHAN_OFS, 32'(SAC_TEMP_CHAN));
    rd(SAC_CHAN_OFS);
    chk(d, 32'(SAC_TEMP_CHAN));
    chk(32'(temp_sensor_sel), 32'h1);
    end_of_test();
  end
endmodule
bind sac_top sac_top_props sac_top_props_inst (.clk_sys, .reset, .reg_addr, .reg_rd, .reg_wr,
  .reg_wdata, .reg_rdata, .sample_hold, .trial_p, .trial_n, .chan_sel, .temp_sensor_sel,
  .input_mode, .busy, .irq);
`default_nettype wire
